/* wwss_top.v */
// Window watchdog and supply supervisor top level.
`timescale 1ns/10ps
`include "wwss_defs.vh"
module wwss_top #(
  parameter        CW           = 34,
  parameter [3:0]  GAP_SEL      = `WWSS_GAP_SEL,
  parameter [33:0] CYC_PER_MS   = `WWSS_CYC_PER_MS,
  parameter [33:0] HOLD_CYC     = `WWSS_HOLD_MS * `WWSS_CYC_PER_MS,
  parameter [33:0] FAST_PLS_CYC = `WWSS_FAST_PULSE_MS * `WWSS_CYC_PER_MS,
  parameter [33:0] SLOW_PLS_CYC = `WWSS_SLOW_PULSE_MS * `WWSS_CYC_PER_MS
) (
  input  wire ref_clk_in,
  input  wire rst_n_in,
  input  wire under_rail_in,
  input  wire over_rail_in,
  input  wire activity_strobe_in,
  input  wire fault_clear_n_in,
  output reg  supply_reset_n_out,
  output wire activity_fault_out_n_out,
  output reg  high_rail_fault_latch_n_out
);
  // --------------------------------------------------------------------------
  // Derived timing limits
  // --------------------------------------------------------------------------
  // All limits are counted in clock cycles so that one counter width serves
  // every timer. The counters saturate, so a stuck input can never wrap a
  // timer back into a range that looks legal.
  localparam [33:0] OV_DLY_CYC  = `WWSS_OV_DLY_CYC;
  localparam [33:0] CLR_W_CYC   = `WWSS_CLR_WIDTH_CYC;
  localparam [33:0] CLR_RST_CYC = `WWSS_CLR_RST_CYC;
  // Selector clipped to the largest option, so the minimum stays within range.
  localparam [3:0]  SEL = (GAP_SEL > `WWSS_GAP_SEL_MAX) ? `WWSS_GAP_SEL_MAX : GAP_SEL;
  localparam [33:0] MIN_GAP_CYC = CYC_PER_MS << SEL;
  localparam [33:0] MAX_GAP_CYC = MIN_GAP_CYC * `WWSS_GAP_RATIO;
  // The gap counter reads one less than the real spacing when the next edge
  // is taken, so the early limit is lowered by one to match.
  localparam [33:0] FAST_LIM_CYC = MIN_GAP_CYC - 34'h1;

  // --------------------------------------------------------------------------
  // Shared arithmetic
  // --------------------------------------------------------------------------
  // Saturating increment shared by every timer in this file.
  function [CW-1:0] wwss_inc;
    input [CW-1:0] v;
    begin
      wwss_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------------
  reg       rst_s1, rst_s2;
  reg [1:0] uv_sy, ov_sy, wdi_sy, clr_sy;
  reg       wdi_d;

  // Reset enters asynchronously but is released through two flops.
  // Every other process resets from rst_s2, so all of them leave reset on
  // the same edge and no counter starts a cycle ahead of its neighbours.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Pins are asynchronous; only the second stage is read by logic.
  // The strobe and clear stages reset to their idle high level, so the
  // release of reset cannot look like a falling edge or a clear request.
  // The cost is two cycles of latency on every pin, which is far below
  // any of the timing limits this block enforces.
  always @(posedge ref_clk_in or negedge rst_s2) begin
    if (!rst_s2) begin
      uv_sy  <= 2'h0;
      ov_sy  <= 2'h0;
      wdi_sy <= 2'h3;
      clr_sy <= 2'h3;
      wdi_d  <= 1'b1;
    end else begin
      uv_sy  <= {uv_sy[0], under_rail_in};
      ov_sy  <= {ov_sy[0], over_rail_in};
      wdi_sy <= {wdi_sy[0], activity_strobe_in};
      clr_sy <= {clr_sy[0], fault_clear_n_in};
      wdi_d  <= wdi_sy[1];
    end
  end

  // Synchronised levels and the strobe falling edge used by the logic below.
  wire uv      = uv_sy[1];
  wire ov      = ov_sy[1];
  wire clr_low = ~clr_sy[1];
  wire wdi_fall = wdi_d & ~wdi_sy[1];

  // --------------------------------------------------------------------------
  // Over-voltage fault latch and clear input
  // --------------------------------------------------------------------------
  reg [CW-1:0] ov_cnt, clr_cnt;
  reg          clr_rst_req;
  wire         ov_seen = (ov_cnt >= OV_DLY_CYC[CW-1:0]);

  // The delay also filters short over-voltage glitches; a clear is only
  // counted while no over-voltage is present, so it cannot race the set.
  // If the set and a completed clear meet in one cycle, the set wins.
  // A long clear also requests a supply reset, as a way for software to
  // force a full restart of the supervised processor.
  always @(posedge ref_clk_in or negedge rst_s2) begin
    if (!rst_s2) begin
      ov_cnt                      <= {CW{1'b0}};
      clr_cnt                     <= {CW{1'b0}};
      clr_rst_req                 <= 1'b0;
      high_rail_fault_latch_n_out <= 1'b1;
    end else begin
      ov_cnt <= ov ? wwss_inc(ov_cnt) : {CW{1'b0}};
      if (ov || !clr_low)
        clr_cnt <= {CW{1'b0}};
      else
        clr_cnt <= wwss_inc(clr_cnt);
      if (ov_seen)
        high_rail_fault_latch_n_out <= 1'b0;
      else if (clr_cnt >= CLR_W_CYC[CW-1:0])
        high_rail_fault_latch_n_out <= 1'b1;
      clr_rst_req <= !ov && (clr_cnt >= CLR_RST_CYC[CW-1:0]);
    end
  end

  // --------------------------------------------------------------------------
  // Supply reset with hold time
  // --------------------------------------------------------------------------
  reg [CW-1:0] hold_cnt;
  reg          rst_rise;
  wire         out_of_window = uv | ov | clr_rst_req;

  // Any excursion during the hold restarts it from zero.
  // rst_rise marks the cycle in which reset is released; the watchdog
  // uses it to forget any reference edge taken while reset was low.
  // The hold counter stops at its limit rather than wrapping.
  always @(posedge ref_clk_in or negedge rst_s2) begin
    if (!rst_s2) begin
      hold_cnt           <= {CW{1'b0}};
      supply_reset_n_out <= 1'b0;
      rst_rise           <= 1'b0;
    end else begin
      rst_rise <= 1'b0;
      if (out_of_window) begin
        hold_cnt           <= {CW{1'b0}};
        supply_reset_n_out <= 1'b0;
      end else if (!supply_reset_n_out) begin
        if (hold_cnt >= HOLD_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
          supply_reset_n_out <= 1'b1;
          rst_rise           <= 1'b1;
        end else begin
          hold_cnt <= wwss_inc(hold_cnt);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Window watchdog
  // --------------------------------------------------------------------------
  reg [CW-1:0] gap_cnt;
  reg          have_ref;
  reg          fast_hit, slow_hit;
  wire         slow_now = have_ref && (gap_cnt >= MAX_GAP_CYC[CW-1:0]);

  // The late fault fires as soon as the maximum gap is passed rather than
  // waiting for an edge that may never come; the reference is then dropped.
  // After any fault the next edge only becomes a new reference, so one bad
  // edge gives one pulse and not a chain of them.
  // A limitation: edges closer than the synchroniser can resolve are lost,
  // which only matters for strobes far shorter than the minimum gap.
  always @(posedge ref_clk_in or negedge rst_s2) begin
    if (!rst_s2) begin
      gap_cnt  <= {CW{1'b0}};
      have_ref <= 1'b0;
      fast_hit <= 1'b0;
      slow_hit <= 1'b0;
    end else begin
      fast_hit <= 1'b0;
      slow_hit <= 1'b0;
      if (rst_rise) begin
        gap_cnt  <= {CW{1'b0}};
        have_ref <= 1'b0;
      end else if (wdi_fall) begin
        gap_cnt <= {CW{1'b0}};
        if (have_ref && (gap_cnt < FAST_LIM_CYC[CW-1:0])) begin
          fast_hit <= 1'b1;
          have_ref <= 1'b0;
        end else if (slow_now) begin
          slow_hit <= 1'b1;
          have_ref <= 1'b0;
        end else begin
          have_ref <= 1'b1;
        end
      end else if (slow_now) begin
        slow_hit <= 1'b1;
        have_ref <= 1'b0;
      end else begin
        gap_cnt <= wwss_inc(gap_cnt);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fault pulse output
  // --------------------------------------------------------------------------
  // Output flop lives in the timer, so the pin still comes from a register.
  // The early pulse is the shorter one; a fault arriving during a pulse
  // restarts it with the new length.
  wwss_pulse_timer #(
    .WIDTH (CW)
  ) u_fault_pulse (
    .clk_in      (ref_clk_in),
    .rst_n_in    (rst_s2),
    .start_in    (fast_hit | slow_hit),
    .length_in   (fast_hit ? FAST_PLS_CYC[CW-1:0] : SLOW_PLS_CYC[CW-1:0]),
    .pulse_n_out (activity_fault_out_n_out)
  );
endmodule

/* wwss_defs.vh */
// Timing constants and gap selector settings for the window watchdog supply supervisor.
`ifndef WWSS_DEFS_VH
`define WWSS_DEFS_VH
`define WWSS_CLK_MHZ        200
`define WWSS_CYC_PER_US     (`WWSS_CLK_MHZ)
`define WWSS_CYC_PER_MS     (`WWSS_CLK_MHZ * 1000)
`define WWSS_OV_DLY_US      5
`define WWSS_OV_DLY_CYC     (`WWSS_OV_DLY_US * `WWSS_CYC_PER_US)
`define WWSS_CLR_WIDTH_NS   400
`define WWSS_CLR_WIDTH_CYC  ((`WWSS_CLR_WIDTH_NS * `WWSS_CLK_MHZ + 999) / 1000)
`define WWSS_CLR_RST_US     5
`define WWSS_CLR_RST_CYC    (`WWSS_CLR_RST_US * `WWSS_CYC_PER_US)
`define WWSS_FAST_PULSE_MS  50
`define WWSS_SLOW_PULSE_MS  100
`define WWSS_HOLD_MS        1
`define WWSS_GAP_SEL        4'h0
`define WWSS_GAP_RATIO      10
`define WWSS_GAP_SEL_MAX    4'hc
`endif

/* wwss_pulse_timer.v */
// Down-counting pulse timer that drives one active-low output.
`timescale 1ns/10ps
module wwss_pulse_timer #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             start_in,
  input  wire [WIDTH-1:0] length_in,
  output reg              pulse_n_out
);
  reg [WIDTH-1:0] remain;

  // --------------------------------------------------------------------------
  // Pulse generation
  // --------------------------------------------------------------------------
  // A new start restarts the count, so back-to-back faults stretch the pulse.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain      <= {WIDTH{1'b0}};
      pulse_n_out <= 1'b1;
    end else if (start_in) begin
      remain      <= length_in;
      pulse_n_out <= 1'b0;
    end else if (remain > {{(WIDTH-1){1'b0}}, 1'b1}) begin
      remain      <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      remain      <= {WIDTH{1'b0}};
      pulse_n_out <= 1'b1;
    end
  end
endmodule

/* wwss_monitor.sv */
// Port-level assertion checker for the window watchdog supply supervisor.
`timescale 1ns/10ps
module wwss_monitor #(
  parameter [33:0] HOLD_CYC     = 50,
  parameter [33:0] FAST_PLS_CYC = 100
) (
  input logic ref_clk_in,
  input logic rst_n_in,
  input logic under_rail_in,
  input logic over_rail_in,
  input logic activity_strobe_in,
  input logic fault_clear_n_in,
  input logic supply_reset_n_out,
  input logic activity_fault_out_n_out,
  input logic high_rail_fault_latch_n_out
);
  int ok_n;
  int hi_n;
  int clear_run;
  int flt_n;
  // Run lengths; a long clear counts as a rail fault because it also forces reset.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ok_n <= 0;
      hi_n <= 0;
      clear_run <= 0;
      flt_n <= 0;
    end else begin
      ok_n <= (under_rail_in | over_rail_in | clear_run >= 995) ? 0 : ok_n + 1;
      hi_n <= over_rail_in ? hi_n + 1 : 0;
      clear_run <= fault_clear_n_in ? 0 : clear_run + 1;
      flt_n <= activity_fault_out_n_out ? 0 : flt_n + 1;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Four samples: two synchroniser stages and the output flop come first.
  sequence s_under4; under_rail_in [*4]; endsequence
  sequence s_over4; over_rail_in [*4]; endsequence
  a_under_reset: assert property (s_under4 |-> !supply_reset_n_out)
    else $error("low rail left reset high");
  a_over_reset: assert property (s_over4 |-> !supply_reset_n_out)
    else $error("high rail left reset high");
  a_hold_min: assert property ($rose(supply_reset_n_out) |-> ok_n >= HOLD_CYC)
    else $error("reset released before hold time");
  a_hold_max: assert property (ok_n >= HOLD_CYC + 12 |-> supply_reset_n_out)
    else $error("reset held past hold time");
  a_over_flag: assert property (hi_n == 1010 |-> !high_rail_fault_latch_n_out)
    else $error("fault flag late");
  a_flag_early: assert property ($fell(high_rail_fault_latch_n_out) |-> hi_n >= 995)
    else $error("fault flag early");
  a_flag_keep: assert property (s_over4 ##0 !high_rail_fault_latch_n_out |=>
    !high_rail_fault_latch_n_out) else $error("flag cleared during high rail");
  a_clear_cause: assert property ($rose(high_rail_fault_latch_n_out) |->
    $past(!fault_clear_n_in, 5) && !over_rail_in) else $error("flag released without clear");
  a_clear_reset: assert property (clear_run >= 1010 |-> !supply_reset_n_out)
    else $error("long clear left reset high");
  a_fault_width: assert property (
    $rose(activity_fault_out_n_out) |-> flt_n >= FAST_PLS_CYC)
    else $error("fault pulse too short");
endmodule
bind wwss_top wwss_monitor #(.HOLD_CYC(HOLD_CYC), .FAST_PLS_CYC(FAST_PLS_CYC)) u_mon (
  .ref_clk_in, .rst_n_in, .under_rail_in, .over_rail_in, .activity_strobe_in,
  .fault_clear_n_in, .supply_reset_n_out, .activity_fault_out_n_out,
  .high_rail_fault_latch_n_out);

/* wwss_cpu_model.sv */
// Processor model that strobes the activity input at a chosen spacing.
`timescale 1ns/10ps
module wwss_cpu_model (
  input  logic ref_clk_in,
  output logic strobe_out
);
  initial strobe_out = 1'b1;
  // Falls come gap cycles apart; the line goes high again early so each fall is clean.
  task automatic kick(input int gap);
    repeat (4) @(negedge ref_clk_in);
    strobe_out = 1'b1;
    repeat (gap - 4) @(negedge ref_clk_in);
    strobe_out = 1'b0;
  endtask
endmodule

/* tb_top.sv */
// Self-checking testbench for the window watchdog supply supervisor.
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, uv, over, clear_n, strobe;
  wire  sup_rst_n, fault_n, flag_n;
  int   errors = 0, check_count = 0;
  // Short millisecond so the long watchdog and hold counts fit a brief run;
  // the default selector then gives a window of 20 to 200 cycles.
  wwss_top #(.CYC_PER_MS(34'h14), .HOLD_CYC(34'h32),
    .FAST_PLS_CYC(34'h64), .SLOW_PLS_CYC(34'hc8)) u_dut (.ref_clk_in(clk),
    .rst_n_in(rst_n), .under_rail_in(uv), .over_rail_in(over),
    .activity_strobe_in(strobe), .fault_clear_n_in(clear_n),
    .supply_reset_n_out(sup_rst_n), .activity_fault_out_n_out(fault_n),
    .high_rail_fault_latch_n_out(flag_n));
  wwss_cpu_model u_cpu (.ref_clk_in(clk), .strobe_out(strobe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Gaps at both window limits, a fast fault, a fresh reference, then a late fault.
  task automatic t_wdog;
    u_cpu.kick(50);
    u_cpu.kick(20);
    u_cpu.kick(200);
    cyc(8);
    chk(fault_n, 1);
    u_cpu.kick(5); cyc(20); chk(fault_n, 0);
    cyc(70); chk(fault_n, 0); cyc(30); chk(fault_n, 1);
    cyc(150); chk(fault_n, 1);
    u_cpu.kick(30); u_cpu.kick(30); cyc(8); chk(fault_n, 1);
    cyc(222); chk(fault_n, 0);
    cyc(150); chk(fault_n, 0); cyc(60); chk(fault_n, 1);
    $display("watchdog test done");
  endtask
  task automatic t_rail;
    uv = 1; cyc(10); chk(sup_rst_n, 0);
    uv = 0; cyc(25); over = 1; cyc(5); over = 0;
    cyc(40); chk(sup_rst_n, 0);
    cyc(30); chk(sup_rst_n, 1);
    $display("rail test done");
  endtask
  task automatic t_flag;
    over = 1; cyc(990); chk(flag_n, 1);
    cyc(20); chk(flag_n, 0); chk(sup_rst_n, 0);
    clear_n = 0; cyc(100); clear_n = 1; cyc(10); chk(flag_n, 0);
    over = 0; clear_n = 0; cyc(40); clear_n = 1; cyc(10); chk(flag_n, 0);
    clear_n = 0; cyc(100); clear_n = 1; cyc(10); chk(flag_n, 1);
    cyc(60); chk(sup_rst_n, 1);
    $display("flag test done");
  endtask
  task automatic t_clear_rst;
    clear_n = 0; cyc(1050); chk(sup_rst_n, 0);
    clear_n = 1; cyc(40); chk(sup_rst_n, 0); cyc(30); chk(sup_rst_n, 1);
    $display("clear reset test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset is held for twelve cycles; the hold must then run its full length.
  task automatic t_boot;
    cyc(12);
    rst_n = 1'b1;
    cyc(45);
    chk(sup_rst_n, 0);
    cyc(25);
    chk(sup_rst_n, 1);
    $display("boot test done");
  endtask
  // Boot check first, then the watchdog: its first interval starts at the first strobe fall after reset rises.
  initial begin
    rst_n = 1'b0;
    uv = 1'b0;
    over = 1'b0;
    clear_n = 1'b1;
    t_boot;
    t_wdog; t_rail; t_flag; t_clear_rst;
    give_verdict;
  end
  // The tests need about 4000 cycles; three times that means a hang.
  initial begin
    #60000;
    errors++;
    give_verdict;
  end
endmodule
